// ### rtl/qie_pkg.sv
// Package of constants and carriers for the queued invalidation engine.
package qie_pkg;

   // -------------------------------------------------------------------
   // Descriptor layout
   // -------------------------------------------------------------------
   localparam int DESC_W = 128;
   localparam int TYPE_LSB = 0;
   localparam int TYPE_W = 4;
   localparam int GRAN_LSB = 4;
   localparam int GRAN_W = 2;
   localparam int DOM_LSB = 16;
   localparam int DOM_W = 16;
   localparam int REQ_LSB = 32;
   localparam int REQ_W = 16;
   localparam int MASK_LSB = 48;
   localparam int MASK_W = 2;
   localparam int RSVD_LO_LSB = 6;
   localparam int RSVD_LO_W = 10;
   localparam int RSVD_HI_LSB = 50;
   localparam int RSVD_HI_W = 78;

   // -------------------------------------------------------------------
   // Encodings
   // -------------------------------------------------------------------
   localparam logic [3:0] TYPE_CONTEXT_FLUSH = 4'h1;
   localparam logic [1:0] GRAN_ALL = 2'h1;
   localparam logic [1:0] GRAN_DOMAIN = 2'h2;
   localparam logic [1:0] GRAN_DEVICE = 2'h3;
   localparam logic [1:0] GRAN_NONE = 2'h0;

   // -------------------------------------------------------------------
   // Pointer and addressing
   // -------------------------------------------------------------------
   localparam int PTR_W = 8;
   localparam logic [PTR_W-1:0] PTR_ZERO = 8'h00;
   localparam logic [PTR_W-1:0] PTR_ONE = 8'h01;
   localparam int SLOT_BYTES = 16;
   localparam int ADDR_W = 64;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT = 3'b001,
      ST_FLUSH = 3'b011,
      ST_EXEC = 3'b010
   } qie_state_t;

   typedef struct packed {
      logic [1:0] gran;
      logic [DOM_W-1:0] domain_tag_field;
      logic [REQ_W-1:0] requester_tag_field;
      logic [REQ_W-1:0] requester_keep_mask;
   } qie_flush_t;

   // Decodes the context flush coarseness; an unknown value is widened to all.
   function automatic logic [1:0] coarsen(input logic [1:0] g);
      coarsen = (g == GRAN_NONE) ? GRAN_ALL : g;
   endfunction

   // Builds the requester tag compare mask from the mask field.
   function automatic logic [REQ_W-1:0] keep_mask(input logic [1:0] m);
      case (m)
         2'h1: keep_mask = 16'hFFFB;
         2'h2: keep_mask = 16'hFFF9;
         2'h3: keep_mask = 16'hFFF8;
         default: keep_mask = 16'hFFFF;
      endcase
   endfunction

endpackage

// ### rtl/qie_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module qie_skid import qie_pkg::*; #(
   parameter int WIDTH = 128
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);

   logic [WIDTH-1:0] mem_ff [2];
   logic [WIDTH-1:0] nxt_mem [2];
   logic rd_ff, nxt_rd, wr_ff, nxt_wr;
   logic [1:0] cnt_ff, nxt_cnt;

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   always_comb begin
      logic push;
      logic pop;
      push = i_valid && (cnt_ff != 2'h2);
      pop = i_ready && (cnt_ff != 2'h0);
      nxt_mem = mem_ff;
      nxt_rd = rd_ff;
      nxt_wr = wr_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wr_ff] = i_data;
         nxt_wr = ~wr_ff;
      end
      if (pop) begin
         nxt_rd = ~rd_ff;
      end
      nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         cnt_ff <= 2'h0;
         mem_ff[0] <= '0;
         mem_ff[1] <= '0;
      end else begin
         rd_ff <= nxt_rd;
         wr_ff <= nxt_wr;
         cnt_ff <= nxt_cnt;
         mem_ff <= nxt_mem;
      end
   end

   assign o_ready = (cnt_ff != 2'h2);
   assign o_valid = (cnt_ff != 2'h0);
   assign o_data = mem_ff[rd_ff];

endmodule

// ### rtl/qie_engine.sv
// Queued invalidation engine: ring fetch, head pointer and context flush decode.
`timescale 1ns/10ps
module qie_engine import qie_pkg::*; #(
   parameter int DEPTH_W = PTR_W
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Configuration and control
   input wire logic i_queued_mode_enable,
   input wire logic [ADDR_W-1:0] i_ring_base,
   input wire logic [PTR_W-1:0] i_ring_slots,
   input wire logic [PTR_W-1:0] i_ring_tail,
   input wire logic i_write_buffer_flush_needed,
   input wire logic i_translation_on_status,
   input wire logic i_interrupt_remap_on_status,
   input wire logic i_wait_timeout_error_flag,
   input wire logic i_ring_error_clear,
   // Memory read port
   output logic o_rd_req,
   output logic [ADDR_W-1:0] o_rd_addr,
   input wire logic i_rd_valid,
   input wire logic [DESC_W-1:0] i_rd_data,
   // Write buffer flush handshake
   output logic o_wbuf_flush_req,
   input wire logic i_wbuf_flush_done,
   // Context flush command to the cache
   output logic o_flush_valid,
   output qie_flush_t o_flush,
   input wire logic i_flush_ready,
   // Status
   output logic o_queued_mode_active_flag,
   output logic o_ring_error_flag,
   output logic [PTR_W-1:0] o_ring_head,
   output logic o_other_desc_valid,
   output logic [DESC_W-1:0] o_other_desc,
   input wire logic i_other_desc_ready
);

   qie_state_t state_ff, nxt_state;
   logic active_ff, nxt_active;
   logic err_ff, nxt_err;
   logic [PTR_W-1:0] head_ff, nxt_head;
   logic rd_req_ff, nxt_rd_req;
   logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
   logic wbuf_ff, nxt_wbuf;
   logic flush_v_ff, nxt_flush_v;
   qie_flush_t flush_ff, nxt_flush;
   logic other_v_ff, nxt_other_v;
   logic [DESC_W-1:0] other_ff, nxt_other;
   logic buf_valid, buf_ready, fill_ready;
   logic [DESC_W-1:0] buf_data;
   logic ring_empty, can_fetch, desc_ok, is_ctx;
   logic unused_status;

   // -------------------------------------------------------------------
   // Descriptor buffer
   // -------------------------------------------------------------------
   qie_skid #(.WIDTH(DESC_W)) u_skid (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_valid(i_rd_valid),
      .i_data(i_rd_data),
      .o_ready(fill_ready),
      .o_valid(buf_valid),
      .o_data(buf_data),
      .i_ready(buf_ready)
   );

   // Translation and remap status never gate the fetch.
   assign unused_status = i_translation_on_status | i_interrupt_remap_on_status;

   assign ring_empty = (head_ff == i_ring_tail);
   assign can_fetch = active_ff && !ring_empty && !err_ff && !i_wait_timeout_error_flag;
   assign is_ctx = (buf_data[TYPE_LSB +: TYPE_W] == TYPE_CONTEXT_FLUSH);
   assign desc_ok = (buf_data[RSVD_LO_LSB +: RSVD_LO_W] == '0) &&
                    (buf_data[RSVD_HI_LSB +: RSVD_HI_W] == '0) &&
                    (buf_data[TYPE_LSB +: TYPE_W] != 4'h0);
   // Words that arrive after a disable are drained so that a later enable starts clean.
   assign buf_ready = (state_ff == ST_WAIT) || !active_ff;

   function automatic logic [PTR_W-1:0] step_head(input logic [PTR_W-1:0] h,
                                                  input logic [PTR_W-1:0] slots);
      // A slot count of zero stands for the full ring of every pointer value.
      step_head = (h == slots - PTR_ONE) ? PTR_ZERO : h + PTR_ONE;
   endfunction

   // -------------------------------------------------------------------
   // Fetch and execute
   // -------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_active = active_ff;
      nxt_err = err_ff;
      nxt_head = head_ff;
      nxt_rd_req = 1'b0;
      nxt_rd_addr = rd_addr_ff;
      nxt_wbuf = wbuf_ff;
      nxt_flush_v = flush_v_ff && !i_flush_ready;
      nxt_flush = flush_ff;
      nxt_other_v = other_v_ff && !i_other_desc_ready;
      nxt_other = other_ff;
      if (i_ring_error_clear) begin
         nxt_err = 1'b0;
      end
      case (state_ff)
         ST_IDLE: begin
            if (can_fetch && fill_ready && !flush_v_ff && !other_v_ff) begin
               nxt_rd_req = 1'b1;
               nxt_rd_addr = i_ring_base + ADDR_W'(head_ff) * ADDR_W'(SLOT_BYTES);
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (buf_valid) begin
               if (!desc_ok) begin
                  nxt_err = 1'b1;
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_head = step_head(head_ff, i_ring_slots);
                  if (is_ctx) begin
                     nxt_flush.gran = coarsen(buf_data[GRAN_LSB +: GRAN_W]);
                     nxt_flush.domain_tag_field = buf_data[DOM_LSB +: DOM_W];
                     nxt_flush.requester_tag_field = buf_data[REQ_LSB +: REQ_W];
                     nxt_flush.requester_keep_mask =
                        keep_mask(buf_data[MASK_LSB +: MASK_W]);
                     if (i_write_buffer_flush_needed) begin
                        nxt_wbuf = 1'b1;
                        nxt_state = ST_FLUSH;
                     end else begin
                        nxt_state = ST_EXEC;
                     end
                  end else begin
                     nxt_other_v = 1'b1;
                     nxt_other = buf_data;
                     nxt_state = ST_IDLE;
                  end
               end
            end
         end
         ST_FLUSH: begin
            if (i_wbuf_flush_done) begin
               nxt_wbuf = 1'b0;
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            nxt_flush_v = 1'b1;
            nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (i_queued_mode_enable && !active_ff) begin
         nxt_active = 1'b1;
      end
      if (!i_queued_mode_enable && active_ff) begin
         nxt_active = 1'b0;
         nxt_head = PTR_ZERO;
         nxt_rd_req = 1'b0;
         nxt_state = ST_IDLE;
         nxt_wbuf = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_ff <= ST_IDLE;
         active_ff <= 1'b0;
         err_ff <= 1'b0;
         head_ff <= PTR_ZERO;
         rd_req_ff <= 1'b0;
         rd_addr_ff <= '0;
         wbuf_ff <= 1'b0;
         flush_v_ff <= 1'b0;
         flush_ff <= '0;
         other_v_ff <= 1'b0;
         other_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         active_ff <= nxt_active;
         err_ff <= nxt_err;
         head_ff <= nxt_head;
         rd_req_ff <= nxt_rd_req;
         rd_addr_ff <= nxt_rd_addr;
         wbuf_ff <= nxt_wbuf;
         flush_v_ff <= nxt_flush_v;
         flush_ff <= nxt_flush;
         other_v_ff <= nxt_other_v;
         other_ff <= nxt_other;
      end
   end

   assign o_rd_req = rd_req_ff;
   assign o_rd_addr = rd_addr_ff;
   assign o_wbuf_flush_req = wbuf_ff;
   assign o_flush_valid = flush_v_ff;
   assign o_flush = flush_ff;
   assign o_queued_mode_active_flag = active_ff;
   assign o_ring_error_flag = err_ff;
   assign o_ring_head = head_ff;
   assign o_other_desc_valid = other_v_ff;
   assign o_other_desc = other_ff;

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_fetch_req;
      o_rd_req;
   endsequence

   sequence s_head_step;
      head_ff != $past(head_ff) && active_ff;
   endsequence

   sequence s_ctx_take;
      state_ff == ST_WAIT && buf_valid && desc_ok && is_ctx && i_queued_mode_enable;
   endsequence

   sequence s_wbuf_hold;
      o_wbuf_flush_req && state_ff == ST_FLUSH;
   endsequence

   chk_head_after_valid: assert property (
      s_head_step |-> $past(state_ff) == ST_WAIT && $past(buf_valid) && $past(desc_ok))
      else $error("head moved without valid descriptor");
   chk_empty_no_fetch: assert property (
      ring_empty && state_ff == ST_IDLE |=> !o_rd_req)
      else $error("fetch from empty ring");
   chk_enable_sets: assert property (
      i_queued_mode_enable && !active_ff |=> o_queued_mode_active_flag)
      else $error("active flag not set");
   chk_fetch_gate: assert property (
      s_fetch_req |-> $past(active_ff) && !$past(err_ff) && !$past(i_wait_timeout_error_flag))
      else $error("fetch while gated");
   chk_fetch_addr: assert property (
      s_fetch_req |-> o_rd_addr == i_ring_base + ADDR_W'($past(head_ff)) * ADDR_W'(SLOT_BYTES))
      else $error("fetch address outside slot");
   chk_disable_clr: assert property (
      !i_queued_mode_enable && active_ff |=>
         !o_queued_mode_active_flag && o_ring_head == PTR_ZERO)
      else $error("disable did not reset head");
   chk_head_wrap: assert property (
      i_ring_slots != PTR_ZERO |->
         o_ring_head < i_ring_slots || !active_ff || $stable(o_ring_head))
      else $error("head beyond ring");
   chk_gran_legal: assert property (
      o_flush_valid |-> o_flush.gran != GRAN_NONE)
      else $error("flush granularity zero");
   chk_wbuf_first: assert property (
      state_ff == ST_FLUSH && !i_wbuf_flush_done |=> !o_flush_valid)
      else $error("flush before write buffer");
   // A context descriptor either waits for the write buffer or goes straight to execution.
   chk_ctx_wbuf: assert property (
      s_ctx_take ##0 i_write_buffer_flush_needed |=> s_wbuf_hold)
      else $error("write buffer flush not requested");
   chk_ctx_direct: assert property (
      s_ctx_take ##0 !i_write_buffer_flush_needed |=> state_ff == ST_EXEC ##1 o_flush_valid)
      else $error("context flush not issued");
   chk_gran_widen: assert property (
      s_ctx_take ##0 buf_data[GRAN_LSB +: GRAN_W] == GRAN_NONE |=> o_flush.gran == GRAN_ALL)
      else $error("reserved coarseness not widened");
   chk_fetch_ungated: assert property (
      state_ff == ST_IDLE && can_fetch && fill_ready && i_queued_mode_enable &&
         !o_flush_valid && !o_other_desc_valid |=> o_rd_req)
      else $error("fetch held back");
   chk_rd_single: assert property (
      o_rd_req |=> !o_rd_req)
      else $error("second fetch while one is outstanding");
   chk_refuse_stall: assert property (
      state_ff == ST_WAIT && buf_valid && !desc_ok && i_queued_mode_enable |=>
         o_ring_error_flag && $stable(o_ring_head))
      else $error("refused descriptor moved head");
   chk_disable_quiet: assert property (
      !i_queued_mode_enable && active_ff |=>
         state_ff == ST_IDLE && !o_wbuf_flush_req && !o_rd_req)
      else $error("disable left work running");
   chk_wrap_zero: assert property (
      state_ff == ST_WAIT && buf_valid && desc_ok && i_queued_mode_enable &&
         head_ff == i_ring_slots - PTR_ONE |=> o_ring_head == PTR_ZERO)
      else $error("head did not wrap");

endmodule

// ### test/qie_ring_mem.sv
// Far side model: descriptor ring memory, write buffer, cache and consumer handshakes.
`timescale 1ns/10ps
module qie_ring_mem import qie_pkg::*; (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Ring read port
   input wire logic i_rd_req,
   input wire logic [ADDR_W-1:0] i_rd_addr,
   input wire logic [ADDR_W-1:0] i_ring_base,
   input wire logic [PTR_W-1:0] i_ring_slots,
   output logic o_rd_valid,
   output logic [DESC_W-1:0] o_rd_data,
   // Handshakes
   input wire logic i_wbuf_flush_req,
   output logic o_wbuf_flush_done,
   input wire logic i_flush_valid,
   output logic o_flush_ready,
   input wire logic i_other_desc_valid,
   output logic o_other_desc_ready,
   // Answer delay and address check
   input wire logic [3:0] i_lat,
   output logic o_addr_fault
);
   logic [DESC_W-1:0] mem [256];
   logic [PTR_W-1:0] slot_ff;
   logic pend_ff;
   logic [3:0] req;
   logic [3:0] ack_ff;
   int cnt_ff [4];

   assign req = {i_other_desc_valid, i_flush_valid, i_wbuf_flush_req, pend_ff};
   assign {o_other_desc_ready, o_flush_ready, o_wbuf_flush_done, o_rd_valid} = ack_ff;

   // Each request is answered after i_lat idle cycles; read data is garbage outside its pulse.
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         pend_ff <= 1'b0;
         ack_ff <= 4'h0;
         slot_ff <= 8'h00;
         o_addr_fault <= 1'b0;
         o_rd_data <= '0;
         for (int k = 0; k < 4; k++) cnt_ff[k] <= 0;
      end else begin
         if (i_rd_req) begin
            pend_ff <= 1'b1;
            slot_ff <= PTR_W'((i_rd_addr - i_ring_base) >> 4);
            if (i_rd_addr < i_ring_base || i_rd_addr[3:0] != 4'h0 ||
                i_rd_addr >= i_ring_base + (64'(i_ring_slots) << 4)) begin
               o_addr_fault <= 1'b1;
            end
         end else if (ack_ff[0]) begin
            pend_ff <= 1'b0;
         end
         for (int k = 0; k < 4; k++) begin
            cnt_ff[k] <= (req[k] && !ack_ff[k] && cnt_ff[k] < int'(i_lat)) ? cnt_ff[k] + 1 : 0;
            ack_ff[k] <= req[k] && !ack_ff[k] && cnt_ff[k] >= int'(i_lat);
         end
         o_rd_data <= (pend_ff && !ack_ff[0] && cnt_ff[0] >= int'(i_lat)) ? mem[slot_ff] : ~o_rd_data;
      end
   end
endmodule

// ### test/qie_engine_tb.sv
// Self-checking testbench of the queued invalidation engine.
`timescale 1ns/10ps
module qie_engine_tb import qie_pkg::*; ;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic en, xlat_on, irem_on, tmo_err, err_clr, wbuf_need;
   logic rd_req, rd_valid, wbuf_req, wbuf_done, fl_valid, fl_ready;
   logic active, ring_err, oth_valid, oth_ready, fault;
   logic [ADDR_W-1:0] base, rd_addr, last_addr;
   logic [PTR_W-1:0] slots, tail, head;
   logic [DESC_W-1:0] rd_data, oth_desc;
   logic [3:0] lat;
   qie_flush_t fl;
   int error_cnt = 0;
   int checked = 0;
   int rd_cnt = 0;
   int wb_cnt = 0;

   always #10 clk_sys = ~clk_sys;

   qie_engine i_qie_engine (.i_clk_sys(clk_sys), .i_rst(rst), .i_queued_mode_enable(en),
      .i_ring_base(base), .i_ring_slots(slots), .i_ring_tail(tail),
      .i_write_buffer_flush_needed(wbuf_need), .i_translation_on_status(xlat_on),
      .i_interrupt_remap_on_status(irem_on), .i_wait_timeout_error_flag(tmo_err),
      .i_ring_error_clear(err_clr), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
      .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wbuf_flush_req(wbuf_req),
      .i_wbuf_flush_done(wbuf_done), .o_flush_valid(fl_valid), .o_flush(fl),
      .i_flush_ready(fl_ready), .o_queued_mode_active_flag(active), .o_ring_error_flag(ring_err),
      .o_ring_head(head), .o_other_desc_valid(oth_valid), .o_other_desc(oth_desc),
      .i_other_desc_ready(oth_ready));

   qie_ring_mem i_qie_ring_mem (.i_clk_sys(clk_sys), .i_rst(rst), .i_rd_req(rd_req),
      .i_rd_addr(rd_addr), .i_ring_base(base), .i_ring_slots(slots), .o_rd_valid(rd_valid),
      .o_rd_data(rd_data), .i_wbuf_flush_req(wbuf_req), .o_wbuf_flush_done(wbuf_done),
      .i_flush_valid(fl_valid), .o_flush_ready(fl_ready), .i_other_desc_valid(oth_valid),
      .o_other_desc_ready(oth_ready), .i_lat(lat), .o_addr_fault(fault));

   always @(posedge clk_sys) begin
      if (rd_req === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
         last_addr <= rd_addr;
      end
      if (wbuf_req === 1'b1 && wbuf_done === 1'b1) wb_cnt <= wb_cnt + 1;
   end

   // -------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic cmp(input string what, input logic [DESC_W-1:0] exp, input logic [DESC_W-1:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return fl_valid;
         1: return active;
         2: return ring_err;
         default: return oth_valid;
      endcase
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic wait_on(input int s, input logic lvl);
      int n;
      for (n = 0; n < 200 && pick(s) !== lvl; n++) step(1);
      if (n == 200) begin
         error_cnt++;
         $display("unexpected wait %0d: expected %b, seen timeout", s, lvl);
         end_of_test();
      end
   endtask

   // Reserved fields are always written as zero.
   function automatic logic [DESC_W-1:0] desc(input logic [3:0] t, input logic [1:0] g,
         input logic [15:0] dom, input logic [15:0] rq, input logic [1:0] m);
      return {78'h0, m, rq, dom, 10'h000, g, t};
   endfunction

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_enable();
      tail = 8'h00;
      base = 64'h0000_0000_0001_0000;
      slots = 8'h10;
      step(2);
      en = 1'b1;
      wait_on(1, 1'b1);
      step(20);
      cmp("reads on empty ring", 0, rd_cnt);
      cmp("head", 0, head);
      $display("test enable done");
   endtask

   task automatic t_context();
      logic [1:0] g [7] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0};
      logic [1:0] m [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
      logic [15:0] km [4] = '{16'hFFFF, 16'hFFFB, 16'hFFF9, 16'hFFF8};
      wbuf_need = 1'b1;
      for (int k = 0; k < 7; k++) begin
         i_qie_ring_mem.mem[k] = desc(4'h1, g[k], 16'h0100 + k, 16'h00A0 + k, m[k]);
      end
      tail = 8'h07;
      for (int k = 0; k < 7; k++) begin
         lat = 4'(k);
         wait_on(0, 1'b1);
         cmp("buffer drained first", k + 1, wb_cnt);
         cmp("coarseness", (g[k] == 2'h0) ? 2'h1 : g[k], fl.gran);
         if (g[k] != 2'h1) cmp("domain", 16'h0100 + k, fl.domain_tag_field);
         if (g[k] == 2'h3) cmp("requester", 16'h00A0 + k, fl.requester_tag_field);
         if (g[k] == 2'h3) cmp("keep mask", km[m[k]], fl.requester_keep_mask);
         wait_on(0, 1'b0);
         cmp("head", k + 1, head);
         cmp("fetch address", base + 16 * k, last_addr);
      end
      $display("test context done");
   endtask

   task automatic t_error();
      int n0;
      wbuf_need = 1'b0;
      xlat_on = 1'b1;
      irem_on = 1'b1;
      lat = 4'h1;
      i_qie_ring_mem.mem[7] = desc(4'h1, 2'h1, 16'h0000, 16'h0000, 2'h0) | 128'h40;
      tail = 8'h08;
      wait_on(2, 1'b1);
      n0 = rd_cnt;
      step(10);
      cmp("reads while faulted", n0, rd_cnt);
      cmp("head on refusal", 7, head);
      i_qie_ring_mem.mem[7] = '0;
      err_clr = 1'b1;
      step(1);
      err_clr = 1'b0;
      cmp("error cleared", 0, ring_err);
      wait_on(2, 1'b1);
      cmp("head on type zero", 7, head);
      i_qie_ring_mem.mem[7] = desc(4'h1, 2'h2, 16'h0777, 16'h0000, 2'h0);
      tmo_err = 1'b1;
      err_clr = 1'b1;
      step(1);
      err_clr = 1'b0;
      n0 = rd_cnt;
      step(10);
      cmp("reads while timed out", n0, rd_cnt);
      tmo_err = 1'b0;
      wait_on(0, 1'b1);
      cmp("domain", 16'h0777, fl.domain_tag_field);
      wait_on(0, 1'b0);
      cmp("head", 8, head);
      cmp("buffer flushes", 7, wb_cnt);
      $display("test error done");
   endtask

   task automatic t_disable();
      en = 1'b0;
      wait_on(1, 1'b0);
      cmp("head after disable", 0, head);
      $display("test disable done");
   endtask

   task automatic t_wrap();
      tail = 8'h00;
      slots = 8'h04;
      base = 64'h0000_0000_0002_0000;
      lat = 4'h3;
      step(1);
      en = 1'b1;
      wait_on(1, 1'b1);
      for (int k = 0; k < 4; k++) begin
         i_qie_ring_mem.mem[k] = desc(4'h2, 2'h0, 16'h0200 + k, 16'h0000, 2'h0);
      end
      tail = 8'h03;
      for (int k = 0; k < 5; k++) begin
         if (k == 3) tail = 8'h01;
         wait_on(3, 1'b1);
         cmp("passed on", desc(4'h2, 2'h0, 16'h0200 + k % 4, 16'h0000, 2'h0), oth_desc);
         wait_on(3, 1'b0);
         cmp("head", (k + 1) % 4, head);
      end
      cmp("address range", 0, fault);
      $display("test wrap done");
   endtask

   initial begin
      en = 1'b0;
      base = '0;
      slots = 8'h10;
      tail = 8'h00;
      wbuf_need = 1'b0;
      xlat_on = 1'b0;
      irem_on = 1'b0;
      tmo_err = 1'b0;
      err_clr = 1'b0;
      lat = 4'h0;
      step(10);
      rst = 1'b0;
      t_enable();
      t_context();
      t_error();
      t_disable();
      t_wrap();
      end_of_test();
   end
endmodule
